/* File: psd_pkg.sv */
// Shared constants and types for the PWM sequence decoder.
// Assumes one clock domain, clk_sys at 50 MHz, and an asynchronous active-high reset.
package psd_pkg;
   localparam int unsigned PSD_CHANNELS   = 4;
   localparam int unsigned PSD_ENTRY_W    = 16;
   localparam int unsigned PSD_CMP_W      = 15;
   localparam int unsigned PSD_POL_BIT    = 15;
   localparam int unsigned PSD_CMP_MSB    = 14;
   localparam int unsigned PSD_FIFO_DEPTH = 16;
   localparam int unsigned PSD_WAVE_CHANS = 3;

   // Load layout encodings on the load_layout port.
   localparam logic [1:0] PSD_LOAD_COMMON     = 2'h0;
   localparam logic [1:0] PSD_LOAD_GROUPED    = 2'h1;
   localparam logic [1:0] PSD_LOAD_INDIVIDUAL = 2'h2;
   localparam logic [1:0] PSD_LOAD_WAVE       = 2'h3;

   // Entries consumed by one step of each layout.
   localparam logic [2:0] PSD_STEP_COMMON  = 3'h1;
   localparam logic [2:0] PSD_STEP_GROUPED = 3'h2;
   localparam logic [2:0] PSD_STEP_FULL    = 3'h4;

   // Reset values.
   localparam logic [14:0] PSD_CMP_RST = 15'h0000;
   localparam logic [14:0] PSD_TOP_RST = 15'h0001;

   // Polarity values of entry bit 15.
   localparam logic PSD_RISE_FIRST = 1'b0;
   localparam logic PSD_FALL_FIRST = 1'b1;

   typedef enum logic [1:0] {
      PSD_ST_IDLE,
      PSD_ST_PRIME,
      PSD_ST_RUN
   } psd_state_t;
endpackage

/* File: psd_top.sv */
// PWM sequence decoder with its four-channel wave counter and an entry FIFO.
// Assumes a read-only DMA port into RAM that answers each granted request once,
// and tasks that arrive as one-cycle pulses synchronous to clk_sys.
// How it works
// - DMA fetches entries, loads compare per layout.
// - Sequence is one or more 16-bit entries.
// - Bit 15 is polarity, bits 14:0 compare.
// - Polarity 0 rises first, 1 falls first.
// - Layout routes values common, grouped or individual.
// - Arbitrary wave layout drives only channels 0-2.
// - Wave layout: three compares plus new top.
// - Repeat N loads every (N+1)th period.
// - Stepped mode ignores repeat and tail delay.
// - Stepped mode loads one step per advance task.
// - Grouped takes one entry per group.
// - Idle begin fetches first step, then generates.
// - Begun event once first step executes.
// - Loop count zero plays sequence exactly once.
// - Finished event when last step starts executing.
// - After finishing, last step keeps playing.
// - Stop ends at period end, idle pins.
// - Only begin task restarts, from its pointer.
// - Up mode wraps at top, edge-aligned.
// - Up-down mode counts back, center-aligned.
// - Fall first: compare 0 low, top high.
`timescale 1ns/1ns

module psd_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 16
) (
   // Clocking
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             clk_en,
   input  wire logic             flush,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [IW-1:0]    wr_idx_reg;
   logic [IW-1:0]    rd_idx_reg;
   logic [CW-1:0]    count_reg;
   logic             push;
   logic             pop;

   assign in_ready  = (count_reg != FULL);
   assign out_valid = (count_reg != '0);
   assign out_data  = mem_reg[rd_idx_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   function automatic logic [IW-1:0] wrap_inc(input logic [IW-1:0] idx);
      return (idx == IW'(DEPTH - 1)) ? '0 : IW'(idx + 1'b1);
   endfunction

   always_ff @(posedge clk_sys) begin
      if (clk_en && push) begin
         mem_reg[wr_idx_reg] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_idx_reg <= '0;
         rd_idx_reg <= '0;
         count_reg  <= '0;
      end else if (clk_en) begin
         if (flush) begin
            wr_idx_reg <= '0;
            rd_idx_reg <= '0;
            count_reg  <= '0;
         end else begin
            if (push) wr_idx_reg <= wrap_inc(wr_idx_reg);
            if (pop) rd_idx_reg <= wrap_inc(rd_idx_reg);
            count_reg <= CW'(count_reg + CW'(push) - CW'(pop));
         end
      end
   end
endmodule

module psd_top
   import psd_pkg::*;
#(
   parameter int unsigned AW    = 32,
   parameter int unsigned LEN_W = 15,
   parameter int unsigned REP_W = 24
) (
   // Clocking and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             clk_en,
   // Configuration
   input  wire logic [1:0]       load_layout,
   input  wire logic             task_stepped_mode,
   input  wire logic             mode_updown,
   input  wire logic [14:0]      period_top_value,
   input  wire logic [3:0]       idle_level,
   input  wire logic [AW-1:0]    sequence_ram_pointer0,
   input  wire logic [AW-1:0]    sequence_ram_pointer1,
   input  wire logic [LEN_W-1:0] sequence_entry_length0,
   input  wire logic [LEN_W-1:0] sequence_entry_length1,
   input  wire logic [REP_W-1:0] sequence_repeat0,
   input  wire logic [REP_W-1:0] sequence_repeat1,
   // Tasks
   input  wire logic [1:0]       sequence_begin_task,
   input  wire logic             advance_step_task,
   input  wire logic             stop_task,
   // Events
   output logic [1:0]            sequence_begun_event,
   output logic [1:0]            sequence_finished_event,
   output logic                  halted_event,
   // DMA read port
   output logic                  dma_req,
   output logic [AW-1:0]         dma_addr,
   input  wire logic             dma_gnt,
   input  wire logic             dma_rvalid,
   input  wire logic [15:0]      dma_rdata,
   // Pins
   output logic [3:0]            pwm_out
);
   psd_state_t        state_reg;
   logic              seq_sel_reg;
   logic [AW-1:0]     base_reg;
   logic [LEN_W-1:0]  len_reg;
   logic [LEN_W-1:0]  fetch_idx_reg;
   logic [LEN_W-1:0]  applied_reg;
   logic              outstanding_reg;
   logic              discard_reg;
   logic              stop_pend_reg;
   logic              step_pend_reg;
   logic              finished_reg;
   logic              begun_pend_reg;
   logic [REP_W-1:0]  rep_cnt_reg;
   logic [15:0]       stage_reg [PSD_CHANNELS];
   logic [2:0]        stage_cnt_reg;
   logic [14:0]       cmp_reg [PSD_CHANNELS];
   logic [3:0]        pol_reg;
   logic [14:0]       top_reg;
   logic [14:0]       cnt_reg;
   logic              down_reg;
   logic              begin_any;
   logic              begin_sel;
   logic              flush;
   logic [2:0]        step_size;
   logic              stage_full;
   logic              period_end;
   logic              load_due;
   logic              apply;
   logic              last_step;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic              fifo_out_ready;
   logic [15:0]       fifo_out_data;

   // Entries per step; a step is the unit loaded at one period boundary.
   function automatic logic [2:0] layout_step(input logic [1:0] layout);
      unique case (layout)
         PSD_LOAD_COMMON:  return PSD_STEP_COMMON;
         PSD_LOAD_GROUPED: return PSD_STEP_GROUPED;
         default:          return PSD_STEP_FULL;
      endcase
   endfunction

   // Picks which staged entry drives a channel.
   function automatic logic [1:0] route(input logic [1:0] layout, input int unsigned ch);
      unique case (layout)
         PSD_LOAD_COMMON:  return 2'h0;
         PSD_LOAD_GROUPED: return (ch < 2) ? 2'h0 : 2'h1;
         default:          return 2'(ch);
      endcase
   endfunction

   assign begin_any  = |sequence_begin_task;
   assign begin_sel  = sequence_begin_task[1] && !sequence_begin_task[0];
   assign flush      = begin_any || stop_task;
   assign step_size  = layout_step(load_layout);
   assign stage_full = (stage_cnt_reg == step_size);
   assign period_end = mode_updown ? (down_reg && cnt_reg <= 15'h0001)
                                   : (cnt_reg >= top_reg - 15'h0001);
   // Stepped mode ignores the repeat count entirely.
   assign load_due   = task_stepped_mode ? step_pend_reg
                                         : (rep_cnt_reg == (seq_sel_reg ? sequence_repeat1
                                                                        : sequence_repeat0));
   assign apply      = stage_full && !finished_reg && !flush
                       && ((state_reg == PSD_ST_PRIME)
                           || (state_reg == PSD_ST_RUN && period_end && load_due
                               && !stop_pend_reg));
   assign last_step  = (LEN_W'(applied_reg + LEN_W'(step_size) + LEN_W'(step_size))
                        > len_reg);
   assign fifo_out_ready = !stage_full && !flush;

   psd_fifo #(
      .WIDTH (PSD_ENTRY_W),
      .DEPTH (PSD_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .clk_en    (clk_en),
      .flush     (flush),
      .in_valid  (dma_rvalid && !discard_reg),
      .in_ready  (fifo_in_ready),
      .in_data   (dma_rdata),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // Sequence control. Loop count is fixed at zero: one pass, then hold.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg      <= PSD_ST_IDLE;
         seq_sel_reg    <= 1'b0;
         base_reg       <= '0;
         len_reg        <= '0;
         applied_reg    <= '0;
         finished_reg   <= 1'b0;
         begun_pend_reg <= 1'b0;
         stop_pend_reg  <= 1'b0;
      end else if (clk_en) begin
         if (begin_any) begin
            seq_sel_reg    <= begin_sel;
            base_reg       <= begin_sel ? sequence_ram_pointer1 : sequence_ram_pointer0;
            len_reg        <= begin_sel ? sequence_entry_length1 : sequence_entry_length0;
            applied_reg    <= '0;
            finished_reg   <= 1'b0;
            begun_pend_reg <= 1'b1;
            stop_pend_reg  <= 1'b0;
            if (state_reg == PSD_ST_IDLE) state_reg <= PSD_ST_PRIME;
         end else if (stop_task) begin
            stop_pend_reg  <= (state_reg == PSD_ST_RUN);
            begun_pend_reg <= 1'b0;
            finished_reg   <= 1'b1;
            if (state_reg == PSD_ST_PRIME) state_reg <= PSD_ST_IDLE;
         end else if (state_reg == PSD_ST_RUN && period_end && stop_pend_reg) begin
            state_reg     <= PSD_ST_IDLE;
            stop_pend_reg <= 1'b0;
         end else if (apply) begin
            state_reg      <= PSD_ST_RUN;
            applied_reg    <= LEN_W'(applied_reg + LEN_W'(step_size));
            begun_pend_reg <= 1'b0;
            finished_reg   <= last_step;
         end
      end
   end

   // DMA fetcher: one read in flight; a response owed to a flushed sequence is dropped.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dma_req         <= 1'b0;
         dma_addr        <= '0;
         fetch_idx_reg   <= '0;
         outstanding_reg <= 1'b0;
         discard_reg     <= 1'b0;
      end else if (clk_en) begin
         if (dma_req && dma_gnt) begin
            dma_req         <= 1'b0;
            outstanding_reg <= 1'b1;
         end else if (dma_rvalid) begin
            outstanding_reg <= 1'b0;
         end
         if (flush) begin
            fetch_idx_reg <= '0;
            discard_reg   <= dma_req || (outstanding_reg && !dma_rvalid);
         end else begin
            if (dma_rvalid) discard_reg <= 1'b0;
            // A grant owed to a flushed sequence must not advance the new fetch index.
            if (dma_req && dma_gnt && !discard_reg) begin
               fetch_idx_reg <= LEN_W'(fetch_idx_reg + 1'b1);
            end
            if (!dma_req && !outstanding_reg && fifo_in_ready && state_reg != PSD_ST_IDLE
                && !stop_pend_reg && fetch_idx_reg < len_reg) begin
               dma_req  <= 1'b1;
               dma_addr <= AW'(base_reg + AW'({fetch_idx_reg, 1'b0}));
            end
         end
      end
   end

   // Staging gathers one step of entries before it may be applied.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stage_cnt_reg <= '0;
         for (int i = 0; i < PSD_CHANNELS; i++) stage_reg[i] <= '0;
      end else if (clk_en) begin
         if (flush || apply) begin
            stage_cnt_reg <= '0;
         end else if (fifo_out_valid && fifo_out_ready) begin
            stage_reg[stage_cnt_reg[1:0]] <= fifo_out_data;
            stage_cnt_reg <= 3'(stage_cnt_reg + 1'b1);
         end
      end
   end

   // Refresh pacing and stepping requests.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rep_cnt_reg   <= '0;
         step_pend_reg <= 1'b0;
      end else if (clk_en) begin
         if (apply || begin_any) begin
            rep_cnt_reg <= '0;
         end else if (state_reg == PSD_ST_RUN && period_end && !load_due) begin
            rep_cnt_reg <= REP_W'(rep_cnt_reg + 1'b1);
         end
         if (advance_step_task) begin
            step_pend_reg <= 1'b1;
         end else if (apply || begin_any) begin
            step_pend_reg <= 1'b0;
         end
      end
   end

   // Compare, polarity and top loaded at a boundary or on priming; outside wave layout top follows period_top_value except mid-period while running.
   generate
      for (genvar ch = 0; ch < PSD_CHANNELS; ch++) begin : g_chan
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               cmp_reg[ch] <= PSD_CMP_RST;
               pol_reg[ch] <= PSD_RISE_FIRST;
            end else if (clk_en && apply) begin
               cmp_reg[ch] <= stage_reg[route(load_layout, ch)][PSD_CMP_MSB:0];
               pol_reg[ch] <= stage_reg[route(load_layout, ch)][PSD_POL_BIT];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         top_reg <= PSD_TOP_RST;
      end else if (clk_en) begin
         if (apply && load_layout == PSD_LOAD_WAVE) begin
            top_reg <= stage_reg[PSD_WAVE_CHANS][PSD_CMP_MSB:0];
         end else if (load_layout != PSD_LOAD_WAVE
                      && (state_reg != PSD_ST_RUN || period_end)) begin
            top_reg <= period_top_value;
         end
      end
   end

   // Wave counter: up mode 0..top-1, up-down adds top..1 on the way back.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_reg  <= '0;
         down_reg <= 1'b0;
      end else if (clk_en) begin
         if (state_reg != PSD_ST_RUN || (state_reg == PSD_ST_PRIME)) begin
            cnt_reg  <= '0;
            down_reg <= 1'b0;
         end else if (period_end) begin
            cnt_reg  <= '0;
            down_reg <= 1'b0;
         end else if (!down_reg && mode_updown && cnt_reg >= top_reg - 15'h0001) begin
            cnt_reg  <= top_reg;
            down_reg <= 1'b1;
         end else if (down_reg) begin
            cnt_reg <= 15'(cnt_reg - 1'b1);
         end else begin
            cnt_reg <= 15'(cnt_reg + 1'b1);
         end
      end
   end

   // Pins follow the counter one clock late; idle level whenever not generating.
   generate
      for (genvar ch = 0; ch < PSD_CHANNELS; ch++) begin : g_pin
         logic active;
         assign active = down_reg ? (cnt_reg <= cmp_reg[ch]) : (cnt_reg < cmp_reg[ch]);
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               pwm_out[ch] <= 1'b0;
            end else if (clk_en) begin
               if (state_reg != PSD_ST_RUN
                   || (load_layout == PSD_LOAD_WAVE && ch >= PSD_WAVE_CHANS)) begin
                  pwm_out[ch] <= idle_level[ch];
               end else begin
                  pwm_out[ch] <= active ^ (pol_reg[ch] == PSD_RISE_FIRST);
               end
            end
         end
      end
   endgenerate

   // Events, one clock pulses.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sequence_begun_event    <= '0;
         sequence_finished_event <= '0;
         halted_event            <= 1'b0;
      end else if (clk_en) begin
         sequence_begun_event    <= '0;
         sequence_finished_event <= '0;
         halted_event            <= state_reg == PSD_ST_RUN && period_end && stop_pend_reg
                                    && !begin_any && !stop_task;
         if (apply && begun_pend_reg) sequence_begun_event[seq_sel_reg] <= 1'b1;
         if (apply && last_step) sequence_finished_event[seq_sel_reg] <= 1'b1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst || !clk_en);

   wave_chan_idle_a: assert property (
      load_layout == PSD_LOAD_WAVE ##1 load_layout == PSD_LOAD_WAVE
      |-> pwm_out[3] == $past(idle_level[3])) else $error("channel 3 active in wave layout");
   // The halt pulse and the idle state arrive together; a begin task may follow at once.
   stop_halt_a: assert property (
      halted_event |-> state_reg == PSD_ST_IDLE ##1 pwm_out == $past(idle_level))
      else $error("pins not idle after halt");
   begun_apply_a: assert property (
      |sequence_begun_event |-> $past(apply) && state_reg == PSD_ST_RUN)
      else $error("begun event without a loaded step");
   finish_hold_a: assert property (
      |sequence_finished_event |-> finished_reg ##1 !apply) else $error("load after finish");
   load_bound_a: assert property (
      $changed(cmp_reg[0]) && $past(state_reg) == PSD_ST_RUN |-> $past(period_end))
      else $error("compare changed mid period");
   wave_top_a: assert property (
      apply && load_layout == PSD_LOAD_WAVE |=> top_reg == $past(stage_reg[3][14:0]))
      else $error("top not taken from entry");
   refresh_pace_a: assert property (
      apply && state_reg == PSD_ST_RUN && !task_stepped_mode
      |-> rep_cnt_reg == (seq_sel_reg ? sequence_repeat1 : sequence_repeat0))
      else $error("load before repeat count");
   step_task_a: assert property (
      apply && state_reg == PSD_ST_RUN && task_stepped_mode |-> step_pend_reg)
      else $error("step without advance task");
   up_wrap_a: assert property (
      state_reg == PSD_ST_RUN && !mode_updown && period_end ##1 state_reg == PSD_ST_RUN
      |-> cnt_reg == 15'h0000) else $error("no wrap at top");
   fall_zero_a: assert property (
      state_reg == PSD_ST_RUN && pol_reg[0] == PSD_FALL_FIRST && cmp_reg[0] == 15'h0000
      && load_layout != PSD_LOAD_WAVE ##1 $stable(cmp_reg[0]) |-> pwm_out[0] == 1'b0)
      else $error("compare 0 not low");

   start_cov_c:  cover property (state_reg == PSD_ST_PRIME ##[1:60] |sequence_begun_event);
   finish_cov_c: cover property (|sequence_finished_event);
   halt_cov_c:   cover property (halted_event);
   wave_cov_c:   cover property (apply && load_layout == PSD_LOAD_WAVE);
   updown_cov_c: cover property (state_reg == PSD_ST_RUN && mode_updown && period_end);
endmodule

/* File: psd_ram_model.sv */
// Behavioural RAM behind the decoder's DMA read port, one read at a time.
// Assumes byte addresses below 512 and a requester that holds dma_req until granted.
`timescale 1ns/1ns
module psd_ram_model #(
   parameter int unsigned AW = 32
) (
   // Clocking and reset
   input  wire logic          clk_sys,
   input  wire logic          rst,
   // DMA read port
   input  wire logic          dma_req,
   input  wire logic [AW-1:0] dma_addr,
   output logic               dma_gnt,
   output logic               dma_rvalid,
   output logic      [15:0]   dma_rdata
);
   logic [15:0]   mem [256];
   logic [AW-1:0] addr_q;
   initial begin
      dma_gnt    = 1'b0;
      dma_rvalid = 1'b0;
      dma_rdata  = 16'h0000;
      forever begin
         @(posedge clk_sys);
         dma_rvalid <= 1'b0;
         // Read data is not held after its pulse, so a late sample sees garbage.
         dma_rdata  <= ~dma_rdata;
         if (dma_req === 1'b1 && rst === 1'b0) begin
            repeat ($urandom_range(0, 2)) @(posedge clk_sys);
            dma_gnt <= 1'b1;
            addr_q = dma_addr;
            @(posedge clk_sys);
            dma_gnt <= 1'b0;
            repeat ($urandom_range(0, 2)) @(posedge clk_sys);
            dma_rvalid <= 1'b1;
            dma_rdata  <= mem[addr_q[8:1]];
         end
      end
   end
endmodule

/* File: pwm_sequence_decoder_tb_top.sv */
// Self-checking bench for the PWM sequence decoder with a RAM model on its DMA port.
// Assumes the RAM model answers every read; both counter modes and a clock-enable freeze are run.
`timescale 1ns/1ns
module pwm_sequence_decoder_tb_top;
   import psd_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst     = 1'b1;
   logic        stm     = 1'b0;
   logic        stp     = 1'b0;
   logic        adv     = 1'b0;
   logic        cen     = 1'b1;
   logic        mud     = 1'b0;
   logic [1:0]  lay     = 2'h0;
   logic [1:0]  beg     = 2'h0;
   logic [14:0] top     = 15'h0008;
   logic [3:0]  idl     = 4'h5;
   logic [31:0] ptr [2] = '{32'h0, 32'h0};
   logic [14:0] len [2] = '{15'h1, 15'h1};
   logic [23:0] rep [2] = '{24'h0, 24'h0};
   logic [1:0]  bev, fev;
   logic        hev, req, gnt, rv;
   logic [3:0]  pwm;
   logic [31:0] addr;
   logic [15:0] rd;
   logic [15:0] ent [4];
   logic [4:0]  nx;
   logic [4:0]  exp_q [$];
   int          bad_count, check_count, cyc, t_b, t_f, per, hi [4];

   always #10 clk_sys = ~clk_sys;

   psd_ram_model u_ram (.clk_sys(clk_sys), .rst(rst), .dma_req(req), .dma_addr(addr),
      .dma_gnt(gnt), .dma_rvalid(rv), .dma_rdata(rd));
   psd_top u_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(cen), .load_layout(lay),
      .task_stepped_mode(stm), .mode_updown(mud), .period_top_value(top),
      .idle_level(idl), .sequence_ram_pointer0(ptr[0]), .sequence_ram_pointer1(ptr[1]),
      .sequence_entry_length0(len[0]), .sequence_entry_length1(len[1]),
      .sequence_repeat0(rep[0]), .sequence_repeat1(rep[1]), .sequence_begin_task(beg),
      .advance_step_task(adv), .stop_task(stp), .sequence_begun_event(bev),
      .sequence_finished_event(fev), .halted_event(hev), .dma_req(req), .dma_addr(addr),
      .dma_gnt(gnt), .dma_rvalid(rv), .dma_rdata(rd), .pwm_out(pwm));

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(string what, logic [15:0] seen, logic [15:0] want);
      check_count++;
      if (seen !== want) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, want, seen);
      end
   endtask

   // Every event pulse must match the oldest note; an unnoted pulse compares against zero.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (bev !== 2'h0) t_b <= cyc;
      if (fev !== 2'h0) t_f <= cyc;
      // Events are unknown until the first reset edge, so reset time is not watched.
      if (!rst && ((bev | fev) !== 2'h0 || hev !== 1'b0)) begin
         nx = (exp_q.size() != 0) ? exp_q.pop_front() : 5'h00;
         check("event", 16'({hev, fev, bev}), 16'(nx));
      end
   end

   task automatic wait_q(int n);
      for (int i = 0; i < 4000 && exp_q.size() > n; i++) @(posedge clk_sys);
      check("pending", 16'(exp_q.size()), 16'(n));
      if (exp_q.size() > n) finish_test();
   endtask

   function automatic int hc(logic [15:0] e, int t);
      int c = (e[14:0] > t) ? t : int'(e[14:0]);
      return e[15] ? c : t - c;
   endfunction

   task automatic duty(int p);
      int cnt [4] = '{default: 0};
      repeat (2 * p + 8) @(posedge clk_sys);
      repeat (p) begin
         @(posedge clk_sys);
         for (int c = 0; c < 4; c++) cnt[c] += pwm[c];
      end
      for (int c = 0; c < 4; c++) check("duty", 16'(cnt[c]), 16'(hi[c]));
   endtask

   task automatic start(int s, int n);
      ptr[s] <= 32'(s * 64 + 16);
      len[s] <= 15'(n);
      for (int i = 0; i < n; i++) begin
         ent[i % 4] = {1'($urandom_range(0, 1)), 15'($urandom_range(0, top + 2))};
         if (lay == PSD_LOAD_WAVE && i == 3) ent[3] = 16'($urandom_range(4, 20));
         u_ram.mem[s * 32 + 8 + i] = ent[i % 4];
      end
      @(posedge clk_sys);
      beg <= 2'(1 << s);
      @(posedge clk_sys);
      beg <= 2'h0;
   endtask

   task automatic halt();
      exp_q.push_back(5'h10);
      stp <= 1'b1;
      @(posedge clk_sys);
      stp <= 1'b0;
      wait_q(0);
      repeat (2) @(posedge clk_sys);
      check("idle", 16'(pwm), 16'(idl));
   endtask

   initial begin
      void'($urandom(36));
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      // Each layout twice, alternating sequences, restarting from idle after a stop.
      // The second round runs the counter up and down.
      for (int k = 0; k < 8; k++) begin
         lay <= 2'(k);
         mud <= 1'(k / 4);
         top <= 15'($urandom_range(4, 20));
         idl <= 4'($urandom);
         rep[k % 2] <= 24'($urandom_range(0, 3));
         @(posedge clk_sys);
         exp_q.push_back(5'(5'h05 << (k % 2)));
         start(k % 2, (k % 4 == 0) ? 1 : (k % 4 == 1) ? 2 : 4);
         wait_q(0);
         per = (lay == PSD_LOAD_WAVE) ? int'(ent[3][14:0]) : int'(top);
         // Up-down doubles the period and every channel's high time.
         for (int c = 0; c < 4; c++) begin
            hi[c] = (lay == PSD_LOAD_COMMON) ? 0 : (lay == PSD_LOAD_GROUPED) ? c / 2 : c;
            hi[c] = hc(ent[hi[c]], per) * (mud + 1);
         end
         if (lay == PSD_LOAD_WAVE) hi[3] = idl[3] * per * (mud + 1);
         duty(per * (mud + 1));
         halt();
         $display("test %0d done", k);
      end
      lay <= PSD_LOAD_COMMON;
      mud <= 1'b0;
      top <= 15'($urandom_range(16, 30));
      rep[0] <= 24'($urandom_range(0, 3));
      @(posedge clk_sys);
      exp_q.push_back(5'h01);
      exp_q.push_back(5'h04);
      start(0, 3);
      wait_q(0);
      hi = '{default: hc(ent[2], top)};
      duty(top);
      check("spacing", 16'(t_f - t_b), 16'(2 * (rep[0] + 1) * top));
      halt();
      $display("test repeat done");
      stm <= 1'b1;
      rep[1] <= 24'h000003;
      @(posedge clk_sys);
      exp_q.push_back(5'h02);
      exp_q.push_back(5'h08);
      start(1, 2);
      wait_q(1);
      repeat (6 * top) @(posedge clk_sys);
      check("stepped", 16'(exp_q.size()), 16'h0001);
      adv <= 1'b1;
      @(posedge clk_sys);
      adv <= 1'b0;
      wait_q(0);
      hi = '{default: hc(ent[1], top)};
      duty(top);
      // With the clock enable low the pins must hold whatever level they had.
      cen <= 1'b0;
      @(posedge clk_sys);
      hi[0] = int'(pwm);
      repeat (3 * top) @(posedge clk_sys);
      check("frozen", 16'(pwm), 16'(hi[0]));
      cen <= 1'b1;
      halt();
      $display("test stepped done");
      finish_test();
   end
endmodule
